// *** rtl/sncc_map.svh ***
`ifndef SNCC_MAP_SVH
`define SNCC_MAP_SVH
// clock and serial line timing
`define SNCC_CLK_HZ       25000000
`define SNCC_BAUD         115200
`define SNCC_BIT_CYC      (`SNCC_CLK_HZ / `SNCC_BAUD)
`define SNCC_HALF_CYC     (`SNCC_BIT_CYC / 2)
// interface restart time, in ms, and its cycle count
`define SNCC_RESTART_MS   5000
`define SNCC_RESTART_CYC  (`SNCC_RESTART_MS * (`SNCC_CLK_HZ / 1000))
// characters of the command protocol
`define SNCC_CH_CR        8'h0d
`define SNCC_CH_SP        8'h20
`define SNCC_CH_DOT       8'h2e
`define SNCC_CH_ZERO      8'h30
`define SNCC_CH_X         8'h58
`define SNCC_CH_I         8'h49
`define SNCC_CH_S         8'h53
`define SNCC_CH_G         8'h47
`define SNCC_CH_V         8'h56
// settings after reset
`define SNCC_IP_RST       32'hc0a8011e
`define SNCC_MASK_RST     32'hffffff00
`define SNCC_GW_RST       32'h00000000
`endif

// *** rtl/sncc_pkg.sv ***
package sncc_pkg;
  // sequencer states
  typedef enum logic [1:0] {S_IDLE, S_ECHO, S_EXEC, S_REPLY} sncc_state_t;
  // decoded command letter
  typedef enum logic [2:0] {CMD_NONE, CMD_IP, CMD_MASK, CMD_GW, CMD_VER, CMD_BAD} sncc_cmd_t;
  // position within the current line
  typedef enum logic [1:0] {PH_START, PH_AFTER, PH_VALUE, PH_SKIP} sncc_phase_t;
  // network settings carried together
  typedef struct packed {
    logic [31:0] ip;
    logic [31:0] mask;
    logic [31:0] gw;
  } sncc_netcfg_t;
endpackage

// *** rtl/sncc_top.sv ***
`timescale 1ns/1ps
`include "sncc_map.svh"
// Functional notes
// - serial link 115.2k, 8N1
// - switch 3 on enables serial commands
// - command letters are case insensitive
// - carriage return ends and executes line
// - empty value replies current setting
// - no prompt is ever sent
// - no line editing characters honoured
// - X then CR abandons line
// - I ip, S mask, G gateway
// - valid set stores, restarts interface
// - restart lasts about five seconds
// - restart aborts ongoing network traffic
// - echo characters, V returns version
// - same protocol over network stream
// - serial reaches all network settings
// - lone X cancels, echoes X only
// - unknown commands silently ignored
// - switch 3 off gives monitor input
module sncc_top #(
  parameter int unsigned RESTART_CYC = `SNCC_RESTART_CYC,  // restart hold, cycles
  parameter int unsigned VER_LEN     = 4,                   // version string length
  parameter logic [8*VER_LEN-1:0] VER_STR = "0.10"          // arbitrary version text
) (
  input  wire logic                 mclk_in,          // 25 MHz clock
  input  wire logic                 arst_n_in,        // async reset, active low
  input  wire logic                 rxd_in,           // serial receive pin
  input  wire logic                 cfg_sw3_in,       // config switch 3 pin
  input  wire logic                 net_rx_valid_in,  // network command byte strobe
  input  wire logic [7:0]           net_rx_data_in,   // network command byte
  output logic                      txd_out,          // serial transmit pin
  output logic                      net_tx_valid_out, // network answer byte strobe
  output logic [7:0]                net_tx_data_out,  // network answer byte
  output logic                      mon_valid_out,    // monitor byte strobe
  output logic [7:0]                mon_data_out,     // monitor byte
  output sncc_pkg::sncc_netcfg_t    net_cfg_out,      // stored settings
  output logic                      store_out,        // persist settings pulse
  output logic                      net_restart_out   // interface held in restart
);
  localparam logic [7:0] BIT_CYC  = 8'(`SNCC_BIT_CYC);
  localparam logic [7:0] HALF_CYC = 8'(`SNCC_HALF_CYC);

  // fold lower case letters onto upper case
  function automatic logic [7:0] fold(input logic [7:0] c);
    fold = (c >= 8'h61 && c <= 8'h7a) ? (c & 8'hdf) : c;
  endfunction
  // octet to three decimal digits
  function automatic logic [11:0] dec3(input logic [7:0] v);
    dec3 = {4'(v / 8'h64), 4'((v / 8'h0a) % 8'h0a), 4'(v % 8'h0a)};
  endfunction

  logic                      rxd_s1_q, rxd_s2_q;     // pin synchroniser
  logic                      sw_s1_q, sw_s2_q;       // switch synchroniser
  logic                      rx_busy_q, rx_vld_q;    // receiver activity, byte strobe
  logic [7:0]                rx_cnt_q, rx_sh_q;      // bit timer, shifter
  logic [3:0]                rx_bit_q;               // received bit index
  logic                      tx_busy_q, txd_q;       // transmitter
  logic [7:0]                tx_cnt_q;               // bit timer
  logic [3:0]                tx_bit_q;               // bits left
  logic [9:0]                tx_sh_q;                // frame shifter
  sncc_pkg::sncc_state_t     st_q;                   // sequencer state
  sncc_pkg::sncc_phase_t     ph_q;                   // line position
  sncc_pkg::sncc_cmd_t       cmd_q;                  // current command
  logic                      src_net_q;              // answers go to network
  logic                      exec_q, have_q, err_q;  // line flags
  logic [7:0]                echo_q;                 // char to echo
  logic [23:0]               val_q;                  // finished octets
  logic [9:0]                oct_q;                  // octet in progress
  logic [1:0]                fld_q, dig_q;           // dots seen, digits in octet
  logic [31:0]               rep_word_q;             // value being replied
  logic                      rep_ver_q;              // replying version
  logic [4:0]                idx_q;                  // reply slot
  sncc_pkg::sncc_netcfg_t    cfg_q;                  // stored settings
  logic                      store_q, restart_q;     // persist pulse, restart level
  logic [31:0]               rs_cnt_q;               // restart timer
  logic                      ntx_vld_q, mon_vld_q;   // output strobes
  logic [7:0]                ntx_dat_q, mon_dat_q;   // output bytes
  // declared ahead: the sequencer reads these before the reply logic drives them
  logic                      tx_idle, rep_skip;      // transmit free, reply slot skipped
  logic [4:0]                rep_last;               // last reply slot

  // two flops on the serial receive and switch pins
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      {rxd_s1_q, rxd_s2_q, sw_s1_q, sw_s2_q} <= 4'hf;
    end else begin
      {rxd_s1_q, rxd_s2_q} <= {rxd_in, rxd_s1_q};
      {sw_s1_q, sw_s2_q}   <= {cfg_sw3_in, sw_s1_q};
    end
  end

  // uart receive
  // middle-of-bit sampling; a start glitch shorter than half a bit is dropped
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rx_busy_q <= 1'b0; rx_vld_q <= 1'b0; rx_cnt_q <= 8'h00;
      rx_bit_q  <= 4'h0; rx_sh_q  <= 8'h00;
    end else begin
      rx_vld_q <= 1'b0;
      if (!rx_busy_q) begin
        if (!rxd_s2_q) begin
          rx_busy_q <= 1'b1; rx_cnt_q <= HALF_CYC; rx_bit_q <= 4'h0;
        end
      end else if (rx_cnt_q != 8'h00) begin
        rx_cnt_q <= rx_cnt_q - 8'h01;
      end else begin
        rx_cnt_q <= BIT_CYC - 8'h01;
        rx_bit_q <= rx_bit_q + 4'h1;
        if (rx_bit_q == 4'h0 && rxd_s2_q) begin
          rx_busy_q <= 1'b0;                   // false start
        end else if (rx_bit_q == 4'h9) begin
          rx_busy_q <= 1'b0;
          rx_vld_q  <= rxd_s2_q;               // framing error drops byte
        end else if (rx_bit_q != 4'h0) begin
          rx_sh_q <= {rxd_s2_q, rx_sh_q[7:1]};
        end
      end
    end
  end

  // serial commands only with switch on; network stream in both switch settings
  wire       ser_vld = sw_s2_q && rx_vld_q;
  wire       in_vld  = ser_vld || net_rx_valid_in;
  wire [7:0] in_raw  = ser_vld ? rx_sh_q : net_rx_data_in;
  wire [7:0] ch      = fold(in_raw);
  wire       proc    = (st_q == sncc_pkg::S_IDLE) && in_vld;
  wire       is_x    = ch == `SNCC_CH_X;
  wire       is_cr   = ch == `SNCC_CH_CR;
  wire       is_dig  = ch >= `SNCC_CH_ZERO && ch <= 8'h39;
  wire [3:0] dval    = 4'(ch - `SNCC_CH_ZERO);
  wire sncc_pkg::sncc_cmd_t dec_cmd =
    (ch == `SNCC_CH_I) ? sncc_pkg::CMD_IP   :
    (ch == `SNCC_CH_S) ? sncc_pkg::CMD_MASK :
    (ch == `SNCC_CH_G) ? sncc_pkg::CMD_GW   :
    (ch == `SNCC_CH_V) ? sncc_pkg::CMD_VER  : sncc_pkg::CMD_BAD;
  // a value char follows the letter, or one space
  wire       val_ch  = (ph_q == sncc_pkg::PH_VALUE) ||
                       (ph_q == sncc_pkg::PH_AFTER && ch != `SNCC_CH_SP);
  wire       dig_bad = is_dig && dig_q == 2'd3;
  wire       dot_bad = (ch == `SNCC_CH_DOT) && (dig_q == 2'd0 || fld_q == 2'd3);
  // any other char, backspace included, spoils the value
  wire       oth_bad = !is_dig && ch != `SNCC_CH_DOT;
  // complete quad with every octet in range
  wire       val_ok  = !err_q && fld_q == 2'd3 && dig_q != 2'd0 && oct_q <= 10'd255;
  wire [31:0] new_val = {val_q, oct_q[7:0]};

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_q <= sncc_pkg::S_IDLE; ph_q <= sncc_pkg::PH_START; cmd_q <= sncc_pkg::CMD_NONE;
      src_net_q <= 1'b0; exec_q <= 1'b0; have_q <= 1'b0; err_q <= 1'b0;
      echo_q <= 8'h00; val_q <= 24'h000000; oct_q <= 10'h000; fld_q <= 2'd0;
      dig_q <= 2'd0; rep_word_q <= 32'h00000000; rep_ver_q <= 1'b0; idx_q <= 5'd0;
      cfg_q <= {`SNCC_IP_RST, `SNCC_MASK_RST, `SNCC_GW_RST}; store_q <= 1'b0;
    end else begin
      store_q <= 1'b0;
      unique case (st_q)
        sncc_pkg::S_IDLE: begin
          if (in_vld) begin
            src_net_q <= !ser_vld;
            echo_q    <= in_raw;
            st_q      <= sncc_pkg::S_ECHO;
            if (is_x) begin
              // cancel at once, echo X, no CR
              echo_q <= `SNCC_CH_X; ph_q <= sncc_pkg::PH_START; cmd_q <= sncc_pkg::CMD_NONE;
              have_q <= 1'b0; err_q <= 1'b0; fld_q <= 2'd0; dig_q <= 2'd0; oct_q <= 10'h000;
            end else if (is_cr) begin
              exec_q <= ph_q != sncc_pkg::PH_START;  // blank line does nothing
            end else if (ph_q == sncc_pkg::PH_START) begin
              cmd_q <= dec_cmd;
              // unknown letter skips rest of line
              ph_q  <= (dec_cmd == sncc_pkg::CMD_BAD) ? sncc_pkg::PH_SKIP : sncc_pkg::PH_AFTER;
            end else if (ph_q == sncc_pkg::PH_AFTER && !val_ch) begin
              ph_q <= sncc_pkg::PH_VALUE;
            end else if (val_ch) begin
              ph_q   <= sncc_pkg::PH_VALUE;
              have_q <= 1'b1;
              if (dig_bad || dot_bad || oth_bad) begin
                err_q <= 1'b1;
              end else if (is_dig) begin
                oct_q <= 10'(oct_q * 10'd10 + {6'd0, dval});
                dig_q <= dig_q + 2'd1;
              end else begin
                val_q <= {val_q[15:0], oct_q[7:0]};
                err_q <= err_q || oct_q > 10'd255;
                fld_q <= fld_q + 2'd1; oct_q <= 10'h000; dig_q <= 2'd0;
              end
            end
          end
        end
        sncc_pkg::S_ECHO: begin
          if (tx_idle) begin
            st_q <= exec_q ? sncc_pkg::S_EXEC : sncc_pkg::S_IDLE;
          end
        end
        sncc_pkg::S_EXEC: begin
          st_q <= sncc_pkg::S_IDLE; exec_q <= 1'b0; idx_q <= 5'd0;
          ph_q <= sncc_pkg::PH_START; cmd_q <= sncc_pkg::CMD_NONE; have_q <= 1'b0;
          err_q <= 1'b0; fld_q <= 2'd0; dig_q <= 2'd0; oct_q <= 10'h000;
          rep_ver_q <= cmd_q == sncc_pkg::CMD_VER;
          rep_word_q <= (cmd_q == sncc_pkg::CMD_IP)   ? cfg_q.ip   :
                        (cmd_q == sncc_pkg::CMD_MASK) ? cfg_q.mask : cfg_q.gw;
          if (cmd_q == sncc_pkg::CMD_VER) begin
            st_q <= sncc_pkg::S_REPLY;
          end else if (cmd_q inside {sncc_pkg::CMD_IP, sncc_pkg::CMD_MASK, sncc_pkg::CMD_GW}) begin
            if (!have_q) begin
              st_q <= sncc_pkg::S_REPLY;
            end else if (val_ok) begin
              store_q <= 1'b1;
              if (cmd_q == sncc_pkg::CMD_IP) cfg_q.ip <= new_val;
              if (cmd_q == sncc_pkg::CMD_MASK) cfg_q.mask <= new_val;
              if (cmd_q == sncc_pkg::CMD_GW) cfg_q.gw <= new_val;
            end
          end
        end
        sncc_pkg::S_REPLY: begin
          if (rep_skip || tx_idle) begin
            idx_q <= idx_q + 5'd1;
            if (idx_q == rep_last) st_q <= sncc_pkg::S_IDLE;
          end
        end
      endcase
    end
  end

  // reply character generator; dotted quad uses four slots per octet
  wire [7:0]  rep_oct  = rep_word_q[8*(3-idx_q[3:2]) +: 8];
  wire [11:0] rep_dig  = dec3(rep_oct);
  assign      rep_last = rep_ver_q ? 5'(VER_LEN) : 5'd15;
  assign      rep_skip = !rep_ver_q && ((idx_q[1:0] == 2'd0 && rep_dig[11:8] == 4'h0) ||
                         (idx_q[1:0] == 2'd1 && rep_dig[11:4] == 8'h00));
  wire [7:0]  rep_ch   = rep_ver_q ? ((idx_q == rep_last) ? `SNCC_CH_CR :
                                      VER_STR[8*(VER_LEN-1-idx_q) +: 8]) :
                         (idx_q[1:0] == 2'd3) ? ((idx_q[3:2] == 2'd3) ? `SNCC_CH_CR : `SNCC_CH_DOT) :
                         `SNCC_CH_ZERO | {4'h0, rep_dig[4*(2-idx_q[1:0]) +: 4]};
  // only echo and reply ever transmit
  assign      tx_idle  = src_net_q || !tx_busy_q;
  wire        send     = tx_idle && ((st_q == sncc_pkg::S_ECHO) ||
                                     (st_q == sncc_pkg::S_REPLY && !rep_skip));
  wire [7:0]  send_ch  = (st_q == sncc_pkg::S_ECHO) ? echo_q : rep_ch;

  // uart transmit, start bit first, one stop bit
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tx_busy_q <= 1'b0; txd_q <= 1'b1; tx_cnt_q <= 8'h00;
      tx_bit_q <= 4'h0; tx_sh_q <= 10'h3ff;
    end else if (send && !src_net_q) begin
      tx_busy_q <= 1'b1; txd_q <= 1'b0; tx_cnt_q <= BIT_CYC - 8'h01;
      tx_bit_q <= 4'h9; tx_sh_q <= {1'b1, send_ch, 1'b0};
    end else if (tx_busy_q) begin
      if (tx_cnt_q != 8'h00) begin
        tx_cnt_q <= tx_cnt_q - 8'h01;
      end else if (tx_bit_q == 4'h0) begin
        tx_busy_q <= 1'b0;
      end else begin
        tx_cnt_q <= BIT_CYC - 8'h01; tx_bit_q <= tx_bit_q - 4'h1;
        tx_sh_q <= {1'b1, tx_sh_q[9:1]}; txd_q <= tx_sh_q[1];
      end
    end
  end

  // restart window; a new store restarts the timer
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      restart_q <= 1'b0; rs_cnt_q <= 32'h00000000;
    end else if (store_q) begin
      restart_q <= 1'b1; rs_cnt_q <= 32'(RESTART_CYC - 1);
    end else if (rs_cnt_q != 32'h00000000) begin
      rs_cnt_q <= rs_cnt_q - 32'h00000001;
    end else begin
      restart_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ntx_vld_q <= 1'b0; ntx_dat_q <= 8'h00; mon_vld_q <= 1'b0; mon_dat_q <= 8'h00;
    end else begin
      ntx_vld_q <= send && src_net_q;
      if (send && src_net_q) ntx_dat_q <= send_ch;
      mon_vld_q <= rx_vld_q && !sw_s2_q;
      if (rx_vld_q && !sw_s2_q) mon_dat_q <= rx_sh_q;
    end
  end

  assign txd_out          = txd_q;
  assign net_tx_valid_out = ntx_vld_q;
  assign net_tx_data_out  = ntx_dat_q;
  assign mon_valid_out    = mon_vld_q;
  assign mon_data_out     = mon_dat_q;
  assign net_cfg_out      = cfg_q;
  assign store_out        = store_q;
  assign net_restart_out  = restart_q;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  a_store_restart: assert property (store_q |=> restart_q[*8])
    else $error("restart not held after store");
  a_restart_cause: assert property ($rose(restart_q) |-> $past(store_q))
    else $error("restart without store");
  a_mon_sw_off: assert property (mon_vld_q |-> !$past(sw_s2_q))
    else $error("monitor byte while switch on");
  a_no_prompt: assert property ($rose(tx_busy_q) || ntx_vld_q
                                |-> $past(st_q) inside {sncc_pkg::S_ECHO, sncc_pkg::S_REPLY})
    else $error("transmit outside echo or reply");
  a_cancel_x: assert property (proc && is_x |=> echo_q == `SNCC_CH_X && !have_q && !exec_q)
    else $error("cancel not applied");
  a_case_fold: assert property (proc && in_raw == 8'h69 && ph_q == sncc_pkg::PH_START
                               |=> cmd_q == sncc_pkg::CMD_IP)
    else $error("lower case letter not decoded");
  a_bad_kept: assert property (st_q == sncc_pkg::S_EXEC && have_q && !val_ok
                               |=> !store_q && $stable(cfg_q))
    else $error("bad value stored");
  a_edit_char: assert property (proc && val_ch && ch == 8'h08 |=> err_q)
    else $error("backspace accepted");
  a_read_reply: assert property (st_q == sncc_pkg::S_EXEC && !have_q && cmd_q == sncc_pkg::CMD_GW
                                 |=> st_q == sncc_pkg::S_REPLY && rep_word_q == cfg_q.gw)
    else $error("empty set did not read back");
  a_store_cr: assert property (store_q |-> $past(st_q) == sncc_pkg::S_EXEC)
    else $error("store without line end");
  c_set_store: cover property (store_q);
  c_version: cover property (st_q == sncc_pkg::S_REPLY && rep_ver_q && send);
  c_cancel: cover property (proc && is_x && ph_q == sncc_pkg::PH_VALUE);
  c_monitor: cover property (mon_vld_q);
endmodule

// *** test/sncc_host.sv ***
`timescale 1ns/1ps
`include "sncc_map.svh"
// host terminal model on the primary serial port, 8 data bits, no parity, 1 stop
module sncc_host (
  input  wire logic       clk_in,       // bench clock
  input  wire logic       txd_in,       // device transmit pin
  output logic            rxd_out,      // device receive pin
  output logic            rx_valid_out, // byte taken from device
  output logic [7:0]      rx_data_out   // that byte
);
  localparam int BIT = `SNCC_BIT_CYC;   // cycles per bit
  logic [7:0]    sh;                    // receive shift value
  int            j;                     // receive bit index
  // line idles at mark level
  initial begin
    rxd_out = 1'b1;
    rx_valid_out = 1'b0;
    rx_data_out = 8'h00;
  end
  task automatic send(input logic [7:0] b);
    logic [9:0] fr;
    int         i;
    fr = {1'b1, b, 1'b0};
    for (i = 0; i < 10; i++) begin
      @(posedge clk_in);
      #1 rxd_out = fr[i];
      repeat (BIT - 1) @(posedge clk_in);
    end
  endtask
  // mid-bit sampling; framing error drops the byte
  always begin
    @(negedge txd_in);
    repeat (BIT / 2) @(posedge clk_in);
    if (txd_in === 1'b0) begin
      for (j = 0; j < 8; j++) begin
        repeat (BIT) @(posedge clk_in);
        sh[j] = txd_in;
      end
      repeat (BIT) @(posedge clk_in);
      if (txd_in === 1'b1) begin
        #1 rx_data_out = sh;
        rx_valid_out = 1'b1;
        @(posedge clk_in);
        #1 rx_valid_out = 1'b0;
      end
    end
  end
endmodule

// *** test/sncc_top_tb.sv ***
`timescale 1ns/1ps
`include "sncc_map.svh"
module sncc_top_tb;
  localparam int          RST_CYC = 20;     // shortened restart hold
  localparam logic [31:0] VER     = "0.10"; // arbitrary version text
  localparam int          LIMIT   = 60000;  // run ceiling, cycles
  localparam int          DLY     = 1;      // drive delay after edge
  logic mclk_in, arst_n_in, cfg_sw3_in, net_rx_valid_in, txd_out, net_tx_valid_out;
  logic mon_valid_out, store_out, net_restart_out, host_valid;
  logic [7:0]             net_rx_data_in, net_tx_data_out, mon_data_out, host_data, mon_last;
  wire logic              rxd_in;           // driven by host model
  sncc_pkg::sncc_netcfg_t net_cfg_out;      // stored settings
  logic [7:0]             got_q[$], exp_q[$]; // seen and expected answer bytes
  bit [31:0]              cfg[3];           // model settings ip, mask, gw
  int n_mismatch, compares, store_cnt, rst_cnt, mon_cnt, exp_store, cyc, tno;
  int                     seed = 44141;     // random seed
  sncc_top #(.RESTART_CYC(RST_CYC), .VER_LEN(4), .VER_STR(VER)) dut (
    .mclk_in(mclk_in), .arst_n_in(arst_n_in), .rxd_in(rxd_in), .cfg_sw3_in(cfg_sw3_in),
    .net_rx_valid_in(net_rx_valid_in), .net_rx_data_in(net_rx_data_in), .txd_out(txd_out),
    .net_tx_valid_out(net_tx_valid_out), .net_tx_data_out(net_tx_data_out),
    .mon_valid_out(mon_valid_out), .mon_data_out(mon_data_out), .net_cfg_out(net_cfg_out),
    .store_out(store_out), .net_restart_out(net_restart_out));
  sncc_host host (.clk_in(mclk_in), .txd_in(txd_out), .rxd_out(rxd_in),
    .rx_valid_out(host_valid), .rx_data_out(host_data));
  // 25 MHz clock
  initial begin
    mclk_in = 1'b0;
    forever #20 mclk_in = ~mclk_in;
  end
  // collect answers from either side, count pulses, cut a hang short
  always @(posedge mclk_in) begin
    if (net_tx_valid_out === 1'b1) got_q.push_back(net_tx_data_out);
    if (host_valid === 1'b1) got_q.push_back(host_data);
    if (store_out === 1'b1) store_cnt++;
    if (net_restart_out === 1'b1) rst_cnt++;
    if (mon_valid_out === 1'b1) begin
      mon_cnt++;
      mon_last = mon_data_out;
    end
    cyc++;
    if (cyc == LIMIT) begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic put(input string s);
    int k;
    for (k = 0; k < s.len(); k++) exp_q.push_back(s[k]);
  endtask
  // reference interpreter: echo all, then read reply or store
  task automatic model(input string s);
    logic [7:0] c;
    bit [31:0]  v;
    int         k, p, f, n, d, ok;
    put(s);
    c = s[0];
    if (c >= 8'h61 && c <= 8'h7a) c = c - 8'h20;
    k = (c == `SNCC_CH_I) ? 0 : (c == `SNCC_CH_S) ? 1 : (c == `SNCC_CH_G) ? 2 : 4;
    if (c == `SNCC_CH_V) k = 3;
    for (p = 0; p < s.len(); p++) if (s[p] == `SNCC_CH_X) k = 4;
    if (s.len() == 2 && k < 3) put($sformatf("%0d.%0d.%0d.%0d\015", cfg[k][31:24],
      cfg[k][23:16], cfg[k][15:8], cfg[k][7:0]));
    if (s.len() == 2 && k == 3) put($sformatf("%s\015", VER));
    if (s.len() > 2 && k < 3) begin
      p = (s[1] == `SNCC_CH_SP) ? 2 : 1;
      v = 0;
      f = 0;
      n = 0;
      d = 0;
      ok = 1;
      while (p < s.len() - 1) begin
        if (s[p] == `SNCC_CH_DOT) begin
          if (n == 0) ok = 0;
          f++;
          v = (v << 8) | d;
          d = 0;
          n = 0;
        end else if (s[p] >= 8'h30 && s[p] <= 8'h39) begin
          d = d * 10 + s[p] - 8'h30;
          n++;
          if (n > 3 || d > 255) ok = 0;
        end else ok = 0;
        p++;
      end
      if (ok == 1 && n > 0 && f == 3) begin
        cfg[k] = (v << 8) | d;
        exp_store = 1;
      end
    end
  endtask
  // one byte by network strobe or by serial frame; idle data is random
  task automatic send(input logic [7:0] b, input bit ser);
    if (ser) begin
      host.send(b);
      repeat (2600) @(posedge mclk_in);
    end else begin
      @(posedge mclk_in);
      #DLY net_rx_valid_in = 1'b1;
      net_rx_data_in = b;
      @(posedge mclk_in);
      #DLY net_rx_valid_in = 1'b0;
      net_rx_data_in = 8'($random(seed));
      repeat (3) @(posedge mclk_in);
    end
  endtask
  // send a whole line, then compare answers, store, restart and settings
  task automatic line(input string s, input bit ser);
    int k, s0, r0;
    got_q.delete();
    exp_q.delete();
    s0 = store_cnt;
    r0 = rst_cnt;
    exp_store = 0;
    model(s);
    for (k = 0; k < s.len(); k++) send(s[k], ser);
    repeat (ser ? 13000 : 60) @(posedge mclk_in);
    chk(got_q.size(), exp_q.size());
    for (k = 0; k < exp_q.size() && k < got_q.size(); k++) chk(got_q[k], exp_q[k]);
    chk(store_cnt - s0, exp_store);
    chk(rst_cnt - r0, exp_store * RST_CYC);
    chk(net_cfg_out.ip, cfg[0]);
    chk(net_cfg_out.mask, cfg[1]);
    chk(net_cfg_out.gw, cfg[2]);
    $display("test %0d done", tno++);
  endtask
  task automatic stop_test();
    $display("compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // main sequence
  initial begin
    logic [31:0] r;
    logic [7:0]  b;
    int          m0;
    arst_n_in = 1'b0;
    cfg_sw3_in = 1'b1;
    net_rx_valid_in = 1'b0;
    net_rx_data_in = 8'h00;
    cfg[0] = `SNCC_IP_RST;
    cfg[1] = `SNCC_MASK_RST;
    cfg[2] = `SNCC_GW_RST;
    repeat (4) @(posedge mclk_in);
    #DLY arst_n_in = 1'b1;
    repeat (8) @(posedge mclk_in);
    chk(got_q.size(), 0);
    chk(txd_out, 1'b1);
    line("I\015", 0);
    line("g 10.0.255.7\015", 0);
    line("S255.255.0.0\015", 0);
    line("s\015", 0);
    line("G\015", 0);
    line("I300.1.1.1\015", 0);
    line("I1.2\010.3.4\015", 0);
    line("I  1.2.3.4\015", 0);
    line("I1.2.3\015", 0);
    line("I1.2X\015", 0);
    line("Q\015", 0);
    line("V\015", 0);
    r = $random(seed);
    line($sformatf("I%0d.%0d.%0d.%0d\015", r[31:24], r[23:16], r[15:8], r[7:0]), 0);
    line("i\015", 0);
    line("V\015", 1);
    // switch off turns the serial port into a monitor input
    @(posedge mclk_in);
    #DLY cfg_sw3_in = 1'b0;
    repeat (4) @(posedge mclk_in);
    b = 8'($random(seed));
    got_q.delete();
    m0 = mon_cnt;
    host.send(b);
    repeat (400) @(posedge mclk_in);
    chk(mon_cnt - m0, 1);
    chk(mon_last, b);
    chk(got_q.size(), 0);
    $display("test %0d done", tno++);
    stop_test();
  end
endmodule
